// ### rtl/slpm_link_params.sv
// Link parameter register bank with per-lane error monitor readback and threshold flags
//
// Overview of operation
// [R1] Converter count byte holds count minus one, reset value one.
// [R2] Control-bits field must stay zero; software keeps it there.
// [R3] Resolution-minus-one field is programmed 0x0F for sixteen bits.
// [R4] Subclass in upper three bits resets to one; width field holds 0xF.
// [R5] Version field 000 or 001, resets 001; samples field zero or one.
// [R6] Software sets high-density bit to one only for one octet per frame.
// [R7] Control-words-per-frame field must stay zero; software keeps it there.
// [R8] Lane zero checksum byte, read/write, reset 0x45, mode from link config bit.
// [R9] Write lane and type selection, then read that address for the count.
// [R10] Write-only lane select bits 6 to 4 pick the monitored lane.
// [R11] Type select 00 disparity, 01 invalid symbol, 10 stray control counter.
// [R12] Deskew mask bit x enables lane x deskew, reset 0x0F.
// [R13] Flag bit x sets when lane x disparity count reaches the threshold.
// [R14] Octets-per-frame field is 0, 1 or 3; this bank does not store it.
// [R15] Reserved bits read zero; spare parameter bytes store what is written.
`timescale 1ns/100ps
`include "slpm_map.svh"

module slpm_link_params #(
  parameter int LANES = 8,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic checksum_mode,
  input wire logic [CNT_W-1:0] error_threshold,
  input wire logic [LANES*CNT_W-1:0] disparity_error_counter,
  input wire logic [LANES*CNT_W-1:0] invalid_symbol_counter,
  input wire logic [LANES*CNT_W-1:0] stray_control_symbol_counter,
  output logic [7:0] converter_count,
  output logic [7:0] control_bits_and_resolution,
  output logic [7:0] subclass_and_sample_width,
  output logic [7:0] version_and_samples,
  output logic [7:0] density_and_control_words,
  output logic [7:0] spare_parameter_one,
  output logic [7:0] spare_parameter_two,
  output logic [7:0] lane_zero_checksum_value,
  output logic lane_zero_checksum_mode,
  output logic [7:0] lane_deskew_enable,
  output logic [7:0] disparity_threshold_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [7:0] converter_count_reg;
  logic [7:0] ctrl_resolution_reg;
  logic [7:0] subclass_width_reg;
  logic [7:0] version_samples_reg;
  logic [7:0] density_ctrl_reg;
  logic [7:0] spare_one_reg;
  logic [7:0] spare_two_reg;
  logic [7:0] checksum_reg;
  logic [7:0] monitor_sel_reg;
  logic [7:0] deskew_mask_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] count_sel_reg;
  logic [7:0] count_sel_next;
  logic [7:0] rdata_next;
  logic checksum_mode_reg;
  logic wr_converter_count;
  logic wr_ctrl_resolution;
  logic wr_subclass_width;
  logic wr_version_samples;
  logic wr_density_ctrl;
  logic wr_spare_one;
  logic wr_spare_two;
  logic wr_checksum;
  logic wr_monitor_sel;
  logic wr_deskew_mask;
  logic [2:0] monitor_lane_select;
  logic [1:0] error_type_select;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] target);
    hit = (addr == target);
  endfunction : hit

  function automatic logic [7:0] keep_bits(input logic [7:0] value, input logic [7:0] mask);
    keep_bits = value & mask;
  endfunction : keep_bits

  function automatic logic [CNT_W-1:0] lane_count(input logic [LANES*CNT_W-1:0] bus, input logic [2:0] lane);
    lane_count = '0;
    if (int'(lane) < LANES) begin
      lane_count = bus[int'(lane)*CNT_W +: CNT_W];
    end
  endfunction : lane_count

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  // One strobe per writable byte; the flag byte has none

  assign wr_converter_count = reg_wr && hit(reg_addr, `SLPM_ADDR_CONVERTER_COUNT);
  assign wr_ctrl_resolution = reg_wr && hit(reg_addr, `SLPM_ADDR_CTRL_RESOLUTION);
  assign wr_subclass_width = reg_wr && hit(reg_addr, `SLPM_ADDR_SUBCLASS_WIDTH);
  assign wr_version_samples = reg_wr && hit(reg_addr, `SLPM_ADDR_VERSION_SAMPLES);
  assign wr_density_ctrl = reg_wr && hit(reg_addr, `SLPM_ADDR_DENSITY_CTRL);
  assign wr_spare_one = reg_wr && hit(reg_addr, `SLPM_ADDR_SPARE_ONE);
  assign wr_spare_two = reg_wr && hit(reg_addr, `SLPM_ADDR_SPARE_TWO);
  assign wr_checksum = reg_wr && hit(reg_addr, `SLPM_ADDR_CHECKSUM);
  assign wr_monitor_sel = reg_wr && hit(reg_addr, `SLPM_ADDR_ERROR_MONITOR);
  assign wr_deskew_mask = reg_wr && hit(reg_addr, `SLPM_ADDR_DESKEW_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_count_reg <= `SLPM_RST_CONVERTER_COUNT; // [R1]
    end else if (wr_converter_count) begin
      converter_count_reg <= reg_wdata; // [R1]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_resolution_reg <= `SLPM_RST_CTRL_RESOLUTION;
    end else if (wr_ctrl_resolution) begin
      ctrl_resolution_reg <= keep_bits(reg_wdata, `SLPM_MASK_CTRL_RESOLUTION); // [R15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      subclass_width_reg <= `SLPM_RST_SUBCLASS_WIDTH; // [R4]
    end else if (wr_subclass_width) begin
      subclass_width_reg <= reg_wdata; // [R4]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      version_samples_reg <= `SLPM_RST_VERSION_SAMPLES; // [R5]
    end else if (wr_version_samples) begin
      version_samples_reg <= reg_wdata; // [R5]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      density_ctrl_reg <= `SLPM_RST_DENSITY_CTRL;
    end else if (wr_density_ctrl) begin
      density_ctrl_reg <= keep_bits(reg_wdata, `SLPM_MASK_DENSITY_CTRL); // [R15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spare_one_reg <= `SLPM_RST_SPARE;
    end else if (wr_spare_one) begin
      spare_one_reg <= reg_wdata; // [R15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spare_two_reg <= `SLPM_RST_SPARE;
    end else if (wr_spare_two) begin
      spare_two_reg <= reg_wdata; // [R15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      checksum_reg <= `SLPM_RST_CHECKSUM; // [R8]
    end else if (wr_checksum) begin
      checksum_reg <= reg_wdata; // [R8]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      monitor_sel_reg <= `SLPM_RST_MONITOR_SEL;
    end else if (wr_monitor_sel) begin
      monitor_sel_reg <= keep_bits(reg_wdata, `SLPM_MASK_MONITOR_SEL); // [R9] [R10] [R11]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deskew_mask_reg <= `SLPM_RST_DESKEW_MASK; // [R12]
    end else if (wr_deskew_mask) begin
      deskew_mask_reg <= reg_wdata; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error monitor selection

  assign monitor_lane_select = monitor_sel_reg[`SLPM_LANE_SEL_MSB:`SLPM_LANE_SEL_LSB]; // [R10]
  assign error_type_select = monitor_sel_reg[`SLPM_TYPE_SEL_MSB:`SLPM_TYPE_SEL_LSB]; // [R11]

  always_comb begin
    count_sel_next = '0;
    unique case (slpm_pkg::slpm_err_type_e'(error_type_select)) // [R11]
      slpm_pkg::SLPM_ERR_DISPARITY: begin
        count_sel_next = 8'(lane_count(disparity_error_counter,
          monitor_lane_select)); // [R10]
      end
      slpm_pkg::SLPM_ERR_INVALID_SYMBOL: begin
        count_sel_next = 8'(lane_count(invalid_symbol_counter,
          monitor_lane_select)); // [R10]
      end
      slpm_pkg::SLPM_ERR_STRAY_CONTROL: begin
        count_sel_next = 8'(lane_count(stray_control_symbol_counter,
          monitor_lane_select)); // [R10]
      end
      slpm_pkg::SLPM_ERR_NONE: begin
        count_sel_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_sel_reg <= 8'h00;
    end else begin
      count_sel_reg <= count_sel_next; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Disparity threshold flags

  always_comb begin
    flags_next = '0;
    for (int i = 0; i < LANES && i < 8; i++) begin
      flags_next[i] = (disparity_error_counter[i*CNT_W +: CNT_W] >= error_threshold); // [R13]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    rdata_next = 8'h00; // [R15]
    unique case (reg_addr)
      `SLPM_ADDR_CONVERTER_COUNT: rdata_next = converter_count_reg;
      `SLPM_ADDR_CTRL_RESOLUTION: rdata_next = ctrl_resolution_reg;
      `SLPM_ADDR_SUBCLASS_WIDTH: rdata_next = subclass_width_reg;
      `SLPM_ADDR_VERSION_SAMPLES: rdata_next = version_samples_reg;
      `SLPM_ADDR_DENSITY_CTRL: rdata_next = density_ctrl_reg;
      `SLPM_ADDR_SPARE_ONE: rdata_next = spare_one_reg;
      `SLPM_ADDR_SPARE_TWO: rdata_next = spare_two_reg;
      `SLPM_ADDR_CHECKSUM: rdata_next = checksum_reg;
      `SLPM_ADDR_ERROR_MONITOR: rdata_next = count_sel_reg; // [R9]
      `SLPM_ADDR_DESKEW_MASK: rdata_next = deskew_mask_reg;
      `SLPM_ADDR_DISPARITY_FLAGS: rdata_next = flags_reg; // [R13]
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksum mode

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      checksum_mode_reg <= 1'b0;
    end else begin
      checksum_mode_reg <= checksum_mode; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the link receiver

  assign converter_count = converter_count_reg;
  assign control_bits_and_resolution = ctrl_resolution_reg;
  assign subclass_and_sample_width = subclass_width_reg;
  assign version_and_samples = version_samples_reg;
  assign density_and_control_words = density_ctrl_reg;
  assign spare_parameter_one = spare_one_reg;
  assign spare_parameter_two = spare_two_reg;
  assign lane_zero_checksum_value = checksum_reg;
  assign lane_zero_checksum_mode = checksum_mode_reg; // [R8]
  assign lane_deskew_enable = deskew_mask_reg; // [R12]
  assign disparity_threshold_flag = flags_reg;

endmodule : slpm_link_params

// ### rtl/slpm_map.svh
// Register offsets, field positions, reset values and write masks of the link parameter bank
`ifndef SLPM_MAP_SVH
`define SLPM_MAP_SVH
`define SLPM_ADDR_CONVERTER_COUNT 12'h456
`define SLPM_ADDR_CTRL_RESOLUTION 12'h457
`define SLPM_ADDR_SUBCLASS_WIDTH 12'h458
`define SLPM_ADDR_VERSION_SAMPLES 12'h459
`define SLPM_ADDR_DENSITY_CTRL 12'h45a
`define SLPM_ADDR_SPARE_ONE 12'h45b
`define SLPM_ADDR_SPARE_TWO 12'h45c
`define SLPM_ADDR_CHECKSUM 12'h45d
`define SLPM_ADDR_ERROR_MONITOR 12'h46b
`define SLPM_ADDR_DESKEW_MASK 12'h46c
`define SLPM_ADDR_DISPARITY_FLAGS 12'h46d
`define SLPM_RST_CONVERTER_COUNT 8'h01
`define SLPM_RST_CTRL_RESOLUTION 8'h0f
`define SLPM_RST_SUBCLASS_WIDTH 8'h2f
`define SLPM_RST_VERSION_SAMPLES 8'h20
`define SLPM_RST_DENSITY_CTRL 8'h80
`define SLPM_RST_SPARE 8'h00
`define SLPM_RST_CHECKSUM 8'h45
`define SLPM_RST_MONITOR_SEL 8'h00
`define SLPM_RST_DESKEW_MASK 8'h0f
`define SLPM_MASK_CTRL_RESOLUTION 8'hdf
`define SLPM_MASK_DENSITY_CTRL 8'h9f
`define SLPM_MASK_MONITOR_SEL 8'h73
`define SLPM_LANE_SEL_MSB 6
`define SLPM_LANE_SEL_LSB 4
`define SLPM_TYPE_SEL_MSB 1
`define SLPM_TYPE_SEL_LSB 0
`define SLPM_CHECKSUM_MODE_BIT 6
`endif

// ### rtl/slpm_pkg.sv
// Types shared by the link parameter bank
package slpm_pkg;
  typedef enum logic [1:0] {
    SLPM_ERR_DISPARITY,
    SLPM_ERR_INVALID_SYMBOL,
    SLPM_ERR_STRAY_CONTROL,
    SLPM_ERR_NONE
  } slpm_err_type_e;
endpackage : slpm_pkg

// ### testbench/slpm_link_params_asserts.sv
// Port assertions for the link parameter bank
`timescale 1ns/100ps
`include "slpm_map.svh"
module slpm_link_params_asserts #(
  parameter int LANES = 8,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic checksum_mode,
  input wire logic [CNT_W-1:0] error_threshold,
  input wire logic [LANES*CNT_W-1:0] disparity_error_counter,
  input wire logic [7:0] converter_count,
  input wire logic [7:0] control_bits_and_resolution,
  input wire logic [7:0] subclass_and_sample_width,
  input wire logic [7:0] version_and_samples,
  input wire logic [7:0] density_and_control_words,
  input wire logic [7:0] spare_parameter_one,
  input wire logic [7:0] spare_parameter_two,
  input wire logic [7:0] lane_zero_checksum_value,
  input wire logic lane_zero_checksum_mode,
  input wire logic [7:0] lane_deskew_enable,
  input wire logic [7:0] disparity_threshold_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sel_wr; reg_wr && reg_addr == `SLPM_ADDR_ERROR_MONITOR && reg_wdata == 8'h00; endsequence
  sequence sel_rd; !reg_wr && reg_rd && reg_addr == `SLPM_ADDR_ERROR_MONITOR; endsequence
  cnt_write_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_CONVERTER_COUNT |=>
    converter_count == $past(reg_wdata)) else $error("converter count write lost");
  resv_mask_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_CTRL_RESOLUTION |=>
    control_bits_and_resolution == ($past(reg_wdata) & 8'hdf)) else $error("reserved bit kept");
  csum_write_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_CHECKSUM |=>
    lane_zero_checksum_value == $past(reg_wdata)) else $error("checksum write lost");
  csum_mode_a: assert property (lane_zero_checksum_mode == $past(checksum_mode))
    else $error("checksum mode not passed");
  deskew_write_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_DESKEW_MASK |=>
    lane_deskew_enable == $past(reg_wdata)) else $error("deskew mask write lost");
  flag_level_a: assert property (!$past(rst) |-> disparity_threshold_flag[LANES-1] ==
    ($past(disparity_error_counter[LANES*CNT_W-1 -: CNT_W]) >= $past(error_threshold))) else $error("flag wrong");
  sel_read_a: assert property (sel_wr ##1 (!reg_wr && !reg_rd) ##1 sel_rd |=>
    reg_rdata == $past(disparity_error_counter[7:0], 2)) else $error("monitor readback wrong");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 12'h400 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  sub_write_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_SUBCLASS_WIDTH |=>
    subclass_and_sample_width == $past(reg_wdata)) else $error("subclass write lost");
  ver_write_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_VERSION_SAMPLES |=>
    version_and_samples == $past(reg_wdata)) else $error("version write lost");
  dens_mask_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_DENSITY_CTRL |=>
    density_and_control_words == ($past(reg_wdata) & 8'h9f)) else $error("density reserved bits kept");
  spare_one_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_SPARE_ONE |=>
    spare_parameter_one == $past(reg_wdata)) else $error("spare one write lost");
  spare_two_a: assert property (reg_wr && reg_addr == `SLPM_ADDR_SPARE_TWO |=>
    spare_parameter_two == $past(reg_wdata)) else $error("spare two write lost");
  flag_read_a: assert property (reg_rd && reg_addr == `SLPM_ADDR_DISPARITY_FLAGS |=>
    reg_rdata == $past(disparity_threshold_flag)) else $error("flag readback differs from port");
endmodule : slpm_link_params_asserts

// ### testbench/slpm_lane_source.sv
// Far-side lane error counter source
`timescale 1ns/100ps
module slpm_lane_source #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bump,
  output logic [LANES*8-1:0] disp,
  output logic [LANES*8-1:0] inv,
  output logic [LANES*8-1:0] stray
);
  always_ff @(posedge clk or posedge rst) begin
    for (int i = 0; i < LANES; i++) begin
      if (rst) disp[i*8 +: 8] <= 8'(i * 4);
      else if (bump) disp[i*8 +: 8] <= disp[i*8 +: 8] + 8'h01;
    end
  end
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      inv[i*8 +: 8] = 8'h40 + 8'(i);
      stray[i*8 +: 8] = 8'h80 + 8'(i);
    end
  end
endmodule : slpm_lane_source

// ### testbench/tb.sv
// Self-checking bench for the link parameter bank
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, csm = 1'b0, bump = 1'b0, mode;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, thr = 8'hff, reg_rdata;
  logic [63:0] disp, inv, stray;
  int miscompares = 0, n_compared = 0;
  logic [11:0] ra [12] = '{12'h456, 12'h457, 12'h458, 12'h459, 12'h45a, 12'h45b, 12'h45c, 12'h45d, 12'h46c,
    12'h46b, 12'h46d, 12'h400};
  logic [7:0] rv [12] = '{8'h01, 8'h0f, 8'h2f, 8'h20, 8'h80, 8'h00, 8'h00, 8'h45, 8'h0f, 8'h00, 8'h00, 8'h00};
  logic [7:0] wd [12] = '{8'h00, 8'h2f, 8'h0f, 8'h01, 8'h60, 8'ha5, 8'h5a, 8'h3c, 8'hf0, 8'h00, 8'hff, 8'h77};
  logic [7:0] we [12] = '{8'h00, 8'h0f, 8'h0f, 8'h01, 8'h00, 8'ha5, 8'h5a, 8'h3c, 8'hf0, 8'h00, 8'h00, 8'h00};
  initial forever #5 clk = ~clk;
  slpm_link_params #(.LANES(8), .CNT_W(8)) u_slpm_link_params (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .checksum_mode(csm),
    .error_threshold(thr), .disparity_error_counter(disp), .invalid_symbol_counter(inv),
    .stray_control_symbol_counter(stray), .converter_count(), .control_bits_and_resolution(),
    .subclass_and_sample_width(), .version_and_samples(), .density_and_control_words(), .spare_parameter_one(),
    .spare_parameter_two(), .lane_zero_checksum_value(), .lane_zero_checksum_mode(mode), .lane_deskew_enable(),
    .disparity_threshold_flag());
  slpm_lane_source #(.LANES(8)) u_slpm_lane_source (.clk(clk), .rst(rst), .bump(bump), .disp(disp), .inv(inv),
    .stray(stray));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rdc
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 12; i++) rdc(ra[i], rv[i]);
    for (int i = 0; i < 12; i++) wr(ra[i], wd[i]);
    for (int i = 0; i < 12; i++) if (i != 9) rdc(ra[i], we[i]);
    for (int l = 0; l < 8; l++) for (int t = 0; t < 4; t++) begin
      wr(12'h46b, {1'b0, 3'(l), 2'b00, 2'(t)});
      rdc(12'h46b, t == 0 ? 8'(l * 4) : t == 1 ? 8'h40 + 8'(l) : t == 2 ? 8'h80 + 8'(l) : 8'h00);
    end
    csm = 1'b1;
    @(negedge clk);
    chk({7'h00, mode}, 8'h01);
    thr = 8'h10;
    rdc(12'h46d, 8'hf0);
    bump = 1'b1;
    repeat (4) @(negedge clk);
    bump = 1'b0;
    rdc(12'h46d, 8'hf8);
    thr = 8'h14;
    rdc(12'h46d, 8'hf0);
    stop_test;
  end
endmodule : tb
bind slpm_link_params slpm_link_params_asserts #(.LANES(LANES), .CNT_W(CNT_W)) u_slpm_link_params_asserts (.*);
